// ---- hdl/lpc_defines.svh ----
// Register map, field positions, codes and reset values of the controller
`ifndef LPC_DEFINES_SVH
`define LPC_DEFINES_SVH
`define ADDR_W 8
`define DATA_W 32
`define A_UNLOCK 8'h00
`define A_CLK_DIV 8'h04
`define A_PIN_CTRL 8'h08
`define A_MSTOP_A 8'h0c
`define A_MSTOP_B 8'h10
`define A_MSTOP_C 8'h14
`define A_MSTOP_D 8'h18
`define A_OP_POWER 8'h1c
`define A_MOSC_WAIT 8'h20
`define A_SOSC_WAIT 8'h24
`define A_STBY_SEL 8'h28
`define A_DEEP_CTRL 8'h2c
`define A_REL_ENA1 8'h30
`define A_REL_ENA2 8'h34
`define A_REL_ENA3 8'h38
`define A_REL_FLG1 8'h3c
`define A_REL_FLG2 8'h40
`define A_REL_FLG3 8'h44
`define A_REL_EDG1 8'h48
`define A_REL_EDG2 8'h4c
`define A_REL_EDG3 8'h50
`define A_IRQ_STAT 8'h54
`define A_IRQ_MASK 8'h58
`define A_PSTATE 8'h5c
`define NUM_DIV 7
`define DIV_STRIDE 4
`define DIV_RATIO_W 3
`define DIV_CNT_W 8
`define CLK_DIV_W 28
`define DIV_IDX_CORE 0
`define DIV_IDX_BUS 5
`define PIN_BUS_HIGH 0
`define PIN_SMEM_HIGH 1
`define MSTOP_RST 32'hffff_ffff
`define BIT_TIMER_W_UNIT1 0
`define BIT_TIMER_W_UNIT0 1
`define BIT_PULSE_GEN_UNIT1 10
`define BIT_PULSE_GEN_UNIT0 11
`define BIT_CONVERTER_UNIT1 16
`define BIT_CAN_0 0
`define BIT_CAN_1 1
`define BIT_ETHERNET 15
`define BIT_SERIAL_PERIPH_1 16
`define BIT_USB 19
`define BIT_CAPTURE_UNIT 22
`define BIT_BACKUP_RAM 7
`define BIT_I2C_2 17
`define BIT_SERIAL_PERIPH_2 22
`define BIT_QUAD_SERIAL 23
`define OPM_HIGH_SPEED 3'h0
`define OPM_LOW_SPEED_1 3'h6
`define OPM_LOW_SPEED_2 3'h7
`define OPM_RST 3'h0
`define WAIT_RST 8'h00
`define STBY_SLEEP 2'h0
`define STBY_ALLSTOP 2'h1
`define STBY_SOFT 2'h2
`define STBY_DEEP 2'h3
`define CUT_KEEP 2'h0
`define CUT_FORBIDDEN 2'h2
`define CUT_FULL 2'h3
`define REL_I2C_DATA 0
`define REL_I2C_CLOCK 1
`define REL_USB 2
`define REL_W 3
`define IRQ_RELEASE 0
`define IRQ_WAKE 1
`define IRQ_PROTECT 2
`define IRQ_W 3
`define PSTATE_W 5
`endif

// ---- hdl/lpc_pkg.sv ----
// Types shared by the low power controller and its clock dividers
`include "lpc_defines.svh"
package lpc_pkg;
    typedef enum logic [`PSTATE_W-1:0] {
        PS_RUN = 5'h01,
        PS_SLEEP = 5'h02,
        PS_ALLSTOP = 5'h04,
        PS_SOFT_STBY = 5'h08,
        PS_DEEP_STBY = 5'h10
    } power_state_t;

    typedef struct packed {
        logic unlock;
        logic [`CLK_DIV_W-1:0] clk_div;
        logic [1:0] pin_ctrl;
        logic [31:0] mstop_a;
        logic [31:0] mstop_b;
        logic [31:0] mstop_c;
        logic [31:0] mstop_d;
        logic [2:0] power_mode_select;
        logic [7:0] main_osc_wait_select;
        logic [7:0] sub_osc_wait_select;
        logic [1:0] stby_sel;
        logic [1:0] deep_power_cut;
        logic [7:0] ena1;
        logic [7:0] ena2;
        logic [7:0] ena3;
        logic [7:0] edg1;
        logic [7:0] edg2;
        logic [7:0] edg3;
        logic [`REL_W-1:0] flg2;
        logic [`REL_W-1:0] pin_prev;
        logic [`IRQ_W-1:0] irq_stat;
        logic [`IRQ_W-1:0] irq_mask;
        power_state_t pstate;
        logic [`DATA_W-1:0] rdata;
    } lpc_state_t;

    typedef struct packed {
        logic [`DIV_CNT_W-1:0] cnt;
        logic lvl;
    } div_state_t;
endpackage

// ---- hdl/div_if.sv ----
// Link between the controller and one clock ratio divider
`timescale 1ns/100ps
`include "lpc_defines.svh"
interface div_if;
    logic [`DIV_RATIO_W-1:0] ratio;
    logic run;
    logic tick;
    logic lvl;
    modport ctrl (output ratio, output run, input tick, input lvl);
    modport div (input ratio, input run, output tick, output lvl);
endinterface

// ---- hdl/clock_ratio_divider.sv ----
// Divides the system clock by a power of two, stops high when halted
`timescale 1ns/100ps
`include "lpc_defines.svh"
module clock_ratio_divider (
    input wire logic i_clk,
    input wire logic i_rst_n,
    div_if.div dv
);
    lpc_pkg::div_state_t q;
    lpc_pkg::div_state_t n;
    logic [`DIV_CNT_W-1:0] last;

    // Terminal count is 2**ratio - 1
    assign last = (`DIV_CNT_W'(1) << dv.ratio) - `DIV_CNT_W'(1);
    assign dv.tick = dv.run && (q.cnt >= last);
    assign dv.lvl = q.lvl;

    // Count while running; a halted clock rests high
    always_comb begin
        n = q;
        if (!dv.run) begin
            n.cnt = '0;
            n.lvl = 1'b1;
        end else if (dv.tick) begin
            n.cnt = '0;
            n.lvl = ~q.lvl;
        end else begin
            n.cnt = q.cnt + `DIV_CNT_W'(1);
        end
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            q <= '0;
            q.lvl <= 1'b1;
        end else begin
            q <= n;
        end
    end
endmodule // clock_ratio_divider

// ---- hdl/low_power_mode_controller.sv ----
// Low power mode controller: clock ratios, module stops, standby sequencing
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/100ps
`include "lpc_defines.svh"
module low_power_mode_controller (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [`ADDR_W-1:0] i_addr,
    input wire logic [`DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [`DATA_W-1:0] o_rdata,
    input wire logic i_wait_instr,
    input wire logic i_wake_irq,
    input wire logic i_i2c2_data_release_input,
    input wire logic i_i2c2_clock_release_input,
    input wire logic i_usb_suspend_resume,
    output logic [`NUM_DIV-1:0] o_div_tick,
    output logic [`NUM_DIV-1:0] o_div_clk,
    output logic o_bus_clock_pin,
    output logic o_sync_mem_clock_pin,
    output logic [31:0] o_module_stop_a,
    output logic [31:0] o_module_stop_b,
    output logic [31:0] o_module_stop_c,
    output logic [31:0] o_module_stop_d,
    output logic [2:0] o_power_mode_select,
    output logic [7:0] o_main_osc_wait_select,
    output logic [7:0] o_sub_osc_wait_select,
    output logic o_cpu_stop,
    output logic o_periph_clock_stop,
    output logic o_osc_stop,
    output logic o_deep_standby,
    output logic o_backup_ram_power_off,
    output logic o_usb_resume_power_off,
    output logic o_voltage_monitor_stop,
    output logic o_por_low_power,
    output logic o_irq
);
    lpc_pkg::lpc_state_t q;
    lpc_pkg::lpc_state_t n;
    logic prot_addr;
    logic wr_ok;
    logic run_core;
    logic run_periph;
    logic in_deep;
    logic [`REL_W-1:0] rel_now;
    logic [`REL_W-1:0] rel_rise;
    logic [`REL_W-1:0] rel_fall;
    logic [`REL_W-1:0] rel_event;
    logic [`REL_W-1:0] rel_edge_sel;
    logic [`REL_W-1:0] rel_enable;
    logic release_any;
    logic [`IRQ_W-1:0] irq_event;
    logic [`NUM_DIV-1:0] div_clk;

    // Clock dividers, one per clock domain
    genvar g;
    generate
        for (g = 0; g < `NUM_DIV; g++) begin : g_div
            div_if u_dif ();
            assign u_dif.ratio = q.clk_div[g*`DIV_STRIDE+:`DIV_RATIO_W];
            assign u_dif.run = (g == `DIV_IDX_CORE) ? run_core : run_periph;
            clock_ratio_divider u_div (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .dv(u_dif.div)
            );
            assign o_div_tick[g] = u_dif.tick;
            assign div_clk[g] = u_dif.lvl;
        end
    endgenerate
    assign o_div_clk = div_clk;

    // Core runs only in run; other clocks also run in sleep
    assign run_core = (q.pstate == lpc_pkg::PS_RUN);
    assign run_periph = run_core || (q.pstate == lpc_pkg::PS_SLEEP);
    assign in_deep = (q.pstate == lpc_pkg::PS_DEEP_STBY);

    // Clock pins: clock or steady high
    assign o_bus_clock_pin = q.pin_ctrl[`PIN_BUS_HIGH] ? 1'b1
                             : div_clk[`DIV_IDX_BUS];
    assign o_sync_mem_clock_pin = q.pin_ctrl[`PIN_SMEM_HIGH] ? 1'b1
                                  : div_clk[`DIV_IDX_BUS];

    // Register-held outputs
    assign o_rdata = q.rdata;
    assign o_module_stop_a = q.mstop_a;
    assign o_module_stop_b = q.mstop_b;
    assign o_module_stop_c = q.mstop_c;
    assign o_module_stop_d = q.mstop_d;
    assign o_power_mode_select = q.power_mode_select;
    assign o_main_osc_wait_select = q.main_osc_wait_select;
    assign o_sub_osc_wait_select = q.sub_osc_wait_select;
    assign o_cpu_stop = !run_core;
    assign o_periph_clock_stop = !run_periph;
    assign o_osc_stop = (q.pstate == lpc_pkg::PS_SOFT_STBY) || in_deep;
    assign o_deep_standby = in_deep;
    assign o_irq = |(q.irq_stat & q.irq_mask);

    // Power cuts apply only while in deep standby
    assign o_backup_ram_power_off = in_deep && q.deep_power_cut[0];
    assign o_usb_resume_power_off = in_deep && q.deep_power_cut[0];
    assign o_voltage_monitor_stop = in_deep
                                    && (q.deep_power_cut == `CUT_FULL);
    assign o_por_low_power = in_deep && (q.deep_power_cut == `CUT_FULL);

    // Release inputs: selected edge (always rising for USB) raises a flag, enabled flag wakes deep standby
    assign rel_now = {i_usb_suspend_resume, i_i2c2_clock_release_input,
                      i_i2c2_data_release_input};
    assign rel_rise = rel_now & ~q.pin_prev;
    assign rel_fall = ~rel_now & q.pin_prev;
    assign rel_edge_sel = {1'b1, q.edg2[`REL_I2C_CLOCK],
                           q.edg2[`REL_I2C_DATA]};
    assign rel_event = (rel_edge_sel & rel_rise)
                       | (~rel_edge_sel & rel_fall);
    assign rel_enable = q.ena2[`REL_W-1:0];
    assign release_any = |(q.flg2 & rel_enable);

    // Registers behind the write unlock
    always_comb begin
        case (i_addr)
            `A_MSTOP_A, `A_MSTOP_B, `A_MSTOP_C, `A_MSTOP_D,
            `A_OP_POWER, `A_MOSC_WAIT, `A_SOSC_WAIT, `A_STBY_SEL,
            `A_DEEP_CTRL, `A_REL_ENA1, `A_REL_ENA2, `A_REL_ENA3,
            `A_REL_FLG2, `A_REL_EDG1, `A_REL_EDG2, `A_REL_EDG3: begin
                prot_addr = 1'b1;
            end
            default: begin
                prot_addr = 1'b0;
            end
        endcase
    end
    assign wr_ok = i_wr && (!prot_addr || q.unlock);

    // Next state: bus access, release flags, power state sequence
    always_comb begin
        n = q;
        n.rdata = '0;
        irq_event = '0;
        n.pin_prev = rel_now;
        if (i_rd) begin
            case (i_addr)
                `A_UNLOCK: n.rdata = 32'(q.unlock);
                `A_CLK_DIV: n.rdata = 32'(q.clk_div);
                `A_PIN_CTRL: n.rdata = 32'(q.pin_ctrl);
                `A_MSTOP_A: n.rdata = q.mstop_a;
                `A_MSTOP_B: n.rdata = q.mstop_b;
                `A_MSTOP_C: n.rdata = q.mstop_c;
                `A_MSTOP_D: n.rdata = q.mstop_d;
                `A_OP_POWER: n.rdata = 32'(q.power_mode_select);
                `A_MOSC_WAIT: n.rdata = 32'(q.main_osc_wait_select);
                `A_SOSC_WAIT: n.rdata = 32'(q.sub_osc_wait_select);
                `A_STBY_SEL: n.rdata = 32'(q.stby_sel);
                `A_DEEP_CTRL: n.rdata = 32'(q.deep_power_cut);
                `A_REL_ENA1: n.rdata = 32'(q.ena1);
                `A_REL_ENA2: n.rdata = 32'(q.ena2);
                `A_REL_ENA3: n.rdata = 32'(q.ena3);
                `A_REL_FLG2: n.rdata = 32'(q.flg2);
                `A_REL_EDG1: n.rdata = 32'(q.edg1);
                `A_REL_EDG2: n.rdata = 32'(q.edg2);
                `A_REL_EDG3: n.rdata = 32'(q.edg3);
                `A_IRQ_STAT: n.rdata = 32'(q.irq_stat);
                `A_IRQ_MASK: n.rdata = 32'(q.irq_mask);
                `A_PSTATE: n.rdata = 32'(q.pstate);
                default: n.rdata = '0;
            endcase
        end
        if (i_wr && !wr_ok) begin
            irq_event[`IRQ_PROTECT] = 1'b1;
        end
        if (wr_ok) begin
            case (i_addr)
                `A_UNLOCK: n.unlock = i_wdata[0];
                `A_CLK_DIV: n.clk_div = i_wdata[`CLK_DIV_W-1:0];
                `A_PIN_CTRL: n.pin_ctrl = i_wdata[1:0];
                `A_MSTOP_A: n.mstop_a = i_wdata;
                `A_MSTOP_B: n.mstop_b = i_wdata;
                `A_MSTOP_C: n.mstop_c = i_wdata;
                `A_MSTOP_D: n.mstop_d = i_wdata;
                `A_OP_POWER: begin
                    // Unlisted codes are dropped
                    if (i_wdata[2:0] == `OPM_HIGH_SPEED
                        || i_wdata[2:0] == `OPM_LOW_SPEED_1
                        || i_wdata[2:0] == `OPM_LOW_SPEED_2) begin
                        n.power_mode_select = i_wdata[2:0];
                    end
                end
                `A_MOSC_WAIT: n.main_osc_wait_select = i_wdata[7:0];
                `A_SOSC_WAIT: n.sub_osc_wait_select = i_wdata[7:0];
                `A_STBY_SEL: n.stby_sel = i_wdata[1:0];
                `A_DEEP_CTRL: begin
                    if (i_wdata[1:0] != `CUT_FORBIDDEN) begin
                        n.deep_power_cut = i_wdata[1:0];
                    end
                end
                `A_REL_ENA1: n.ena1 = i_wdata[7:0];
                `A_REL_ENA2: n.ena2 = i_wdata[7:0];
                `A_REL_ENA3: n.ena3 = i_wdata[7:0];
                `A_REL_FLG2: n.flg2 = q.flg2 & ~i_wdata[`REL_W-1:0];
                `A_REL_EDG1: n.edg1 = i_wdata[7:0];
                `A_REL_EDG2: n.edg2 = i_wdata[7:0];
                `A_REL_EDG3: n.edg3 = i_wdata[7:0];
                `A_IRQ_STAT: n.irq_stat = q.irq_stat & ~i_wdata[`IRQ_W-1:0];
                `A_IRQ_MASK: n.irq_mask = i_wdata[`IRQ_W-1:0];
                default: n.unlock = q.unlock;
            endcase
        end
        // A new event beats a clear in the same cycle
        n.flg2 = n.flg2 | rel_event;
        case (q.pstate)
            lpc_pkg::PS_RUN: begin
                if (i_wait_instr) begin
                    case (q.stby_sel)
                        `STBY_SLEEP: n.pstate = lpc_pkg::PS_SLEEP;
                        `STBY_ALLSTOP: n.pstate = lpc_pkg::PS_ALLSTOP;
                        `STBY_SOFT: n.pstate = lpc_pkg::PS_SOFT_STBY;
                        default: n.pstate = lpc_pkg::PS_DEEP_STBY;
                    endcase
                end
            end
            lpc_pkg::PS_SLEEP, lpc_pkg::PS_ALLSTOP,
            lpc_pkg::PS_SOFT_STBY: begin
                if (i_wake_irq) begin
                    n.pstate = lpc_pkg::PS_RUN;
                    irq_event[`IRQ_WAKE] = 1'b1;
                end
            end
            lpc_pkg::PS_DEEP_STBY: begin
                if (release_any) begin
                    n.pstate = lpc_pkg::PS_RUN;
                    irq_event[`IRQ_RELEASE] = 1'b1;
                end
            end
            default: n.pstate = lpc_pkg::PS_RUN;
        endcase
        n.irq_stat = n.irq_stat | irq_event;
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            q <= '0;
            q.mstop_a <= `MSTOP_RST;
            q.mstop_b <= `MSTOP_RST;
            q.mstop_c <= `MSTOP_RST;
            q.mstop_d <= `MSTOP_RST;
            q.power_mode_select <= `OPM_RST;
            q.main_osc_wait_select <= `WAIT_RST;
            q.sub_osc_wait_select <= `WAIT_RST;
            q.deep_power_cut <= `CUT_KEEP;
            q.pstate <= lpc_pkg::PS_RUN;
        end else begin
            q <= n;
        end
    end

    // Checks on the controller's behaviour
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    property p_div_ratio;
        (wr_ok && i_addr == `A_CLK_DIV) |=>
            g_div[`DIV_IDX_BUS].u_dif.ratio
            == $past(i_wdata[`DIV_IDX_BUS*`DIV_STRIDE +: `DIV_RATIO_W]);
    endproperty
    a_div_ratio: assert property (p_div_ratio)
        else $error("bus clock ratio not taken from write");

    property p_bus_pin_high;
        (wr_ok && i_addr == `A_PIN_CTRL && i_wdata[`PIN_BUS_HIGH])
            |=> o_bus_clock_pin;
    endproperty
    a_bus_pin_high: assert property (p_bus_pin_high)
        else $error("bus clock pin not held high");

    property p_smem_pin;
        (q.pin_ctrl[`PIN_SMEM_HIGH] == 1'b0)
            |-> o_sync_mem_clock_pin == div_clk[`DIV_IDX_BUS];
    endproperty
    a_smem_pin: assert property (p_smem_pin)
        else $error("memory clock pin not following clock");

    property p_locked_stop;
        (i_wr && !q.unlock && i_addr == `A_MSTOP_A) |=> $stable(q.mstop_a);
    endproperty
    a_locked_stop: assert property (p_locked_stop)
        else $error("locked module stop write took effect");

    property p_stop_b_usb;
        (wr_ok && i_addr == `A_MSTOP_B)
            |=> o_module_stop_b[`BIT_USB] == $past(i_wdata[`BIT_USB]);
    endproperty
    a_stop_b_usb: assert property (p_stop_b_usb)
        else $error("usb stop bit not written");

    property p_stop_c_ram;
        (wr_ok && i_addr == `A_MSTOP_C) |=> o_module_stop_c[`BIT_BACKUP_RAM]
            == $past(i_wdata[`BIT_BACKUP_RAM]);
    endproperty
    a_stop_c_ram: assert property (p_stop_c_ram)
        else $error("backup ram stop bit not written");

    property p_mode_legal;
        o_power_mode_select == `OPM_HIGH_SPEED
            || o_power_mode_select == `OPM_LOW_SPEED_1
            || o_power_mode_select == `OPM_LOW_SPEED_2;
    endproperty
    a_mode_legal: assert property (p_mode_legal)
        else $error("power mode holds an unlisted code");

    property p_mode_hold;
        !$past(wr_ok && i_addr == `A_OP_POWER)
            |-> $stable(o_power_mode_select);
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("power mode changed without a write");

    property p_deep_full_cut;
        (in_deep && q.deep_power_cut == `CUT_FULL) |-> o_voltage_monitor_stop
            && o_por_low_power && o_backup_ram_power_off;
    endproperty
    a_deep_full_cut: assert property (p_deep_full_cut)
        else $error("full deep cut not applied");

    property p_cut_never_forbidden;
        q.deep_power_cut != `CUT_FORBIDDEN;
    endproperty
    a_cut_never_forbidden: assert property (p_cut_never_forbidden)
        else $error("forbidden deep cut code stored");

    property p_flag_sets;
        (q.edg2[`REL_I2C_DATA] && !q.pin_prev[`REL_I2C_DATA]
            && i_i2c2_data_release_input) |=> q.flg2[`REL_I2C_DATA];
    endproperty
    a_flag_sets: assert property (p_flag_sets)
        else $error("data release flag missed a rising edge");

    property p_deep_stays;
        (in_deep && !release_any) |=> o_deep_standby;
    endproperty
    a_deep_stays: assert property (p_deep_stays)
        else $error("left deep standby without release");

    property p_deep_entry;
        (q.pstate == lpc_pkg::PS_RUN && i_wait_instr
            && q.stby_sel == `STBY_DEEP) |=> o_deep_standby ##0 o_osc_stop;
    endproperty
    a_deep_entry: assert property (p_deep_entry)
        else $error("wait did not enter deep standby");
endmodule // low_power_mode_controller

// ---- verif/low_power_mode_controller_tb.sv ----
// Self-checking bench for the low power mode controller
`timescale 1ns/100ps
`include "lpc_defines.svh"
module low_power_mode_controller_tb;
    logic i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0;
    logic wait_in = 0, wake = 0, rel_d = 0, rel_c = 0, rel_u = 0;
    logic [7:0] addr = 0;
    logic [31:0] wdata = 0, rdata, ms_a, ms_b, ms_c, ms_d, exp;
    logic [6:0] dclk, tick;
    logic [2:0] pm;
    logic [7:0] mw, sw;
    logic bus_pin, mem_pin, cpu_s, per_s, osc_s, deep, ram, usb, vmon;
    logic por, irq;
    logic [7:0] ad [3];
    logic [31:0] vl [3];
    int n_fail = 0, tests_run = 0, n;

    low_power_mode_controller i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_addr(addr), .i_wdata(wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(rdata), .i_wait_instr(wait_in), .i_wake_irq(wake),
        .i_i2c2_data_release_input(rel_d), .i_i2c2_clock_release_input(rel_c),
        .i_usb_suspend_resume(rel_u), .o_div_tick(tick), .o_div_clk(dclk),
        .o_bus_clock_pin(bus_pin), .o_sync_mem_clock_pin(mem_pin),
        .o_module_stop_a(ms_a), .o_module_stop_b(ms_b), .o_module_stop_c(ms_c),
        .o_module_stop_d(ms_d), .o_power_mode_select(pm),
        .o_main_osc_wait_select(mw), .o_sub_osc_wait_select(sw),
        .o_cpu_stop(cpu_s),
        .o_periph_clock_stop(per_s), .o_osc_stop(osc_s), .o_deep_standby(deep),
        .o_backup_ram_power_off(ram), .o_usb_resume_power_off(usb),
        .o_voltage_monitor_stop(vmon), .o_por_low_power(por), .o_irq(irq));

    // 25 MHz clock
    initial begin
        forever #20 i_clk = ~i_clk;
    end

    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task cyc(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        addr <= a;
        wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clk);
        addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask

    task wfi();
        @(posedge i_clk);
        wait_in <= 1'b1;
        @(posedge i_clk);
        wait_in <= 1'b0;
        cyc(2);
    endtask

    task rises(input int i, input int e);
        logic p;
        cyc(4);
        p = dclk[i];
        n = 0;
        repeat (32) begin
            cyc(1);
            n += int'(dclk[i] & ~p);
            p = dclk[i];
        end
        chk(n, e);
    endtask

    task end_sim();
        $display("Checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (6000) @(posedge i_clk);
        n_fail++;
        end_sim();
    end

    // Main test sequence
    initial begin
        ad = '{`A_MSTOP_A, `A_MSTOP_B, `A_MSTOP_C};
        vl = '{32'h0001_0c03, 32'h0049_8003, 32'h00c2_0080};
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rdc(`A_MSTOP_A, 32'hffff_ffff);
        wr(`A_MSTOP_A, 32'h0);
        rdc(`A_MSTOP_A, 32'hffff_ffff);
        rdc(`A_IRQ_STAT, 32'h4);
        rdc(8'h80, 32'h0);
        $display("lock test done");
        wr(`A_UNLOCK, 32'h1);
        for (int i = 0; i < 3; i++) begin
            wr(ad[i], vl[i]);
            rdc(ad[i], vl[i]);
        end
        chk(ms_a, vl[0]);
        chk(ms_b, vl[1]);
        chk(ms_c, vl[2]);
        rdc(`A_MSTOP_D, 32'hffff_ffff);
        chk(ms_d, 32'hffff_ffff);
        $display("module stop test done");
        exp = 0;
        for (int i = 0; i < 8; i++) begin
            wr(`A_OP_POWER, i);
            if (i == 0 || i == 6 || i == 7)
                exp = i;
            cyc(1);
            chk(pm, exp);
        end
        wr(`A_MOSC_WAIT, 32'ha5);
        rdc(`A_MOSC_WAIT, 32'ha5);
        wr(`A_SOSC_WAIT, 32'h5a);
        rdc(`A_SOSC_WAIT, 32'h5a);
        chk({mw, sw}, 32'ha55a);
        $display("mode test done");
        wr(`A_CLK_DIV, 32'h1);
        rises(0, 8);
        rises(1, 16);
        wr(`A_PIN_CTRL, 32'h3);
        rises(`DIV_IDX_BUS, 16);
        repeat (4) begin
            cyc(1);
            chk({bus_pin, mem_pin}, 2'h3);
        end
        wr(`A_PIN_CTRL, 32'h0);
        cyc(2);
        exp = {bus_pin, mem_pin};
        cyc(1);
        chk({bus_pin, mem_pin}, {30'h0, ~exp[1:0]});
        $display("clock test done");
        for (int s = 0; s < 3; s++) begin
            wr(`A_STBY_SEL, s);
            wfi();
            chk({cpu_s, per_s, osc_s}, {1'b1, s >= 1, s >= 2});
            chk(pm, 3'h7);
            chk(tick, (s == 0) ? 32'h7e : 32'h0);
            rdc(`A_PSTATE, 32'h1 << (s + 1));
            @(posedge i_clk);
            wake <= 1'b1;
            @(posedge i_clk);
            wake <= 1'b0;
            cyc(2);
            chk(cpu_s, 1'b0);
        end
        rdc(`A_IRQ_STAT, 32'h6);
        $display("state test done");
        wr(`A_STBY_SEL, `STBY_DEEP);
        wr(`A_DEEP_CTRL, `CUT_FULL);
        wr(`A_REL_ENA2, 32'h1);
        wr(`A_REL_EDG2, 32'h1);
        wr(`A_IRQ_STAT, 32'h7);
        wfi();
        chk({deep, ram, usb, vmon, por}, 5'h1f);
        cyc(5);
        chk(deep, 1'b1);
        @(posedge i_clk);
        rel_d <= 1'b1;
        cyc(3);
        chk(deep, 1'b0);
        rdc(`A_REL_FLG2, 32'h1);
        rdc(`A_IRQ_STAT, 32'h1);
        wr(`A_IRQ_MASK, 32'h1);
        cyc(1);
        chk(irq, 1'b1);
        wr(`A_IRQ_STAT, 32'h1);
        cyc(1);
        chk(irq, 1'b0);
        $display("deep release test done");
        wr(`A_DEEP_CTRL, 32'h1);
        wr(`A_DEEP_CTRL, `CUT_FORBIDDEN);
        rdc(`A_DEEP_CTRL, 32'h1);
        wr(`A_REL_ENA2, 32'h6);
        wr(`A_REL_FLG2, 32'h7);
        wfi();
        chk({deep, ram, usb, vmon, por}, 5'h1c);
        @(posedge i_clk);
        rel_c <= 1'b1;
        cyc(3);
        chk(deep, 1'b1);
        @(posedge i_clk);
        rel_u <= 1'b1;
        cyc(3);
        chk(deep, 1'b0);
        rdc(`A_REL_FLG2, 32'h4);
        @(posedge i_clk);
        rel_c <= 1'b0;
        cyc(2);
        rdc(`A_REL_FLG2, 32'h6);
        $display("deep cut test done");
        end_sim();
    end
endmodule // low_power_mode_controller_tb
